// *** ppw_regs.vh ***
/*
 * Register map, field positions, reset values and encodings of the pulse
 * period/width measurement timer. It is included by the timer module and the bench.
 */
`ifndef PPW_REGS_VH
`define PPW_REGS_VH

`define PPW_ADDR_W 8
`define PPW_OFS_MODE 8'h00
`define PPW_OFS_VALUE 8'h04
`define PPW_OFS_START 8'h08
`define PPW_OFS_STATUS 8'h0c
`define PPW_OFS_MASK 8'h10
`define PPW_OFS_COUNT 8'h14

`define PPW_MODE_OP 1:0
`define PPW_MODE_EDGE 3:2
`define PPW_MODE_SRC 7:6
`define PPW_MODE_KEEP 8'hcf
`define PPW_MODE_RST 8'h00
`define PPW_OP_MEASURE 2'h2
`define PPW_EDGE_FALL 2'h0
`define PPW_EDGE_RISE 2'h1
`define PPW_EDGE_BOTH 2'h2
`define PPW_SRC_DIV2 2'h0
`define PPW_SRC_DIV16 2'h1
`define PPW_SRC_DIV64 2'h2
`define PPW_SRC_DIV512 2'h3
`define PPW_PRE_W 9
`define PPW_MASK_DIV2 9'h001
`define PPW_MASK_DIV16 9'h00f
`define PPW_MASK_DIV64 9'h03f
`define PPW_MASK_DIV512 9'h1ff

`define PPW_IRQ_W 2
`define PPW_IRQ_CAP 0
`define PPW_IRQ_OVF 1
`define PPW_IRQ_RST 2'h0

`define PPW_RESP_OKAY 2'h0
`define PPW_RESP_SLVERR 2'h2

`endif

// *** ppw_measure.v ***
/*
 * Pulse period/width measurement timer with an AXI4-Lite register slave.
 * Assumes aclk is the oscillator clock, aresetn is synchronous to aclk and
 * pulse_measure_input is an asynchronous pin driven from outside.
 */
// Function
// R1: Mode field value binary 10 selects period/width measurement.
// R2: Edge field 00 picks falling edges, 01 rising edges, 10 both edges, 11 none.
// R3: Source field picks the oscillator clock divided by 2, 16, 64 or 512.
// R4: With the start flag set the counter adds one on every count source clock.
// R5: On each effective edge the counter value is copied into the buffer.
// R6: A read of the capture value register returns the buffer.
// R7: After each capture the counter restarts from zero and keeps counting.
// R8: Each capture sets a sticky request bit until software clears it.
// R9: The capture at the first edge after start raises no request.
// R10: A counter overflow also raises the timer request.
// R11: The source keeps edges two count clocks apart and avoids overflow.
// R12: Software decides whether a width sample was a high or a low phase.
// R13: Software sets the pin direction to input before use.
// R14: Mode bits five and four are ignored on write and read as zero.
// R15: Counter and buffer are sixteen bits wide.
// R16: The start flag gates counting and a value write clears it.
// R17: The counter wraps to zero and the pin is synchronised before edge detection.
`timescale 1ns/1ps
`include "ppw_regs.vh"

module ppw_measure #(
	parameter CNT_W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire [`PPW_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`PPW_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pulse_measure_input,
	output wire irq
);

	function [`PPW_PRE_W-1:0] src_mask;
		input [1:0] src;
		begin
			case (src)
				`PPW_SRC_DIV2: src_mask = `PPW_MASK_DIV2;
				`PPW_SRC_DIV16: src_mask = `PPW_MASK_DIV16;
				`PPW_SRC_DIV64: src_mask = `PPW_MASK_DIV64;
				default: src_mask = `PPW_MASK_DIV512;
			endcase
		end
	endfunction

	function [7:0] lane_merge;
		input [7:0] old;
		input [7:0] new_byte;
		input strobe;
		begin
			lane_merge = strobe ? new_byte : old;
		end
	endfunction

	reg awready_q;
	reg wready_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg arready_q;
	reg rvalid_q;
	reg [1:0] rresp_q;
	reg [31:0] rdata_q;
	reg aw_have_q;
	reg w_have_q;
	reg [`PPW_ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	reg [7:0] mode_q;
	reg start_q;
	reg first_q;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg [CNT_W-1:0] buf_q;
	reg [CNT_W-1:0] buf_d;
	reg [`PPW_IRQ_W-1:0] sts_q;
	reg [`PPW_IRQ_W-1:0] mask_q;
	reg irq_q;
	reg [`PPW_PRE_W-1:0] pre_q;
	reg pin_s1_q;
	reg pin_s2_q;
	reg pin_s3_q;

	wire aw_fire = s_axi_awvalid & awready_q;
	wire w_fire = s_axi_wvalid & wready_q;
	wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
	wire ar_fire = s_axi_arvalid & arready_q;
	wire wr_mode = wr_go & (awaddr_q == `PPW_OFS_MODE);
	wire wr_value = wr_go & (awaddr_q == `PPW_OFS_VALUE);
	wire wr_start = wr_go & (awaddr_q == `PPW_OFS_START) & wstrb_q[0];
	wire wr_status = wr_go & (awaddr_q == `PPW_OFS_STATUS) & wstrb_q[0];
	wire wr_mask = wr_go & (awaddr_q == `PPW_OFS_MASK) & wstrb_q[0];
	wire wr_known = (awaddr_q == `PPW_OFS_MODE) | (awaddr_q == `PPW_OFS_VALUE) |
		(awaddr_q == `PPW_OFS_START) | (awaddr_q == `PPW_OFS_STATUS) |
		(awaddr_q == `PPW_OFS_MASK) | (awaddr_q == `PPW_OFS_COUNT);

	// R1: measurement mode decode.
	wire measure_on = (mode_q[`PPW_MODE_OP] == `PPW_OP_MEASURE);
	wire running = measure_on & start_q;

	// R3: count source divider.
	wire [`PPW_PRE_W-1:0] div_mask = src_mask(mode_q[`PPW_MODE_SRC]);
	wire tick = ((pre_q & div_mask) == div_mask);

	// R2: effective edge select on the synchronised pin.
	wire rise = pin_s2_q & ~pin_s3_q;
	wire fall = ~pin_s2_q & pin_s3_q;
	reg edge_hit;
	always @* begin
		case (mode_q[`PPW_MODE_EDGE])
			`PPW_EDGE_FALL: edge_hit = fall;
			`PPW_EDGE_RISE: edge_hit = rise;
			`PPW_EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	end

	wire capture = running & edge_hit;
	wire overflow = running & ~capture & tick & (&cnt_q);
	// R9: the first capture after start is silent.
	wire cap_irq = capture & ~first_q;

	// Counter and buffer next values; a value write wins over counting.
	always @* begin
		cnt_d = cnt_q;
		buf_d = buf_q;
		if (wr_value) begin
			cnt_d[7:0] = lane_merge(cnt_q[7:0], wdata_q[7:0], wstrb_q[0]);
			cnt_d[15:8] = lane_merge(cnt_q[15:8], wdata_q[15:8], wstrb_q[1]);
			buf_d[7:0] = lane_merge(buf_q[7:0], wdata_q[7:0], wstrb_q[0]);
			buf_d[15:8] = lane_merge(buf_q[15:8], wdata_q[15:8], wstrb_q[1]);
		end else if (capture) begin
			// R5: counter copied into the buffer.
			buf_d = cnt_q;
			// R7: restart from zero after capture.
			cnt_d = {CNT_W{1'b0}};
		end else if (running & tick) begin
			// R4: count up on each source clock.
			// R17: wrap from all ones to zero.
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			pre_q <= {`PPW_PRE_W{1'b0}};
		end else begin
			// R17: two-stage synchroniser before edge detection.
			pin_s1_q <= pulse_measure_input;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pre_q <= pre_q + {{(`PPW_PRE_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= `PPW_MODE_RST;
			start_q <= 1'b0;
			first_q <= 1'b0;
			cnt_q <= {CNT_W{1'b0}};
			buf_q <= {CNT_W{1'b0}};
			sts_q <= `PPW_IRQ_RST;
			mask_q <= `PPW_IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			// R14: bits five and four are not stored.
			if (wr_mode)
				mode_q <= wdata_q[7:0] & `PPW_MODE_KEEP;
			// R16: a value write halts counting.
			if (wr_value) begin
				start_q <= 1'b0;
				first_q <= 1'b0;
			end else if (wr_start) begin
				start_q <= wdata_q[0];
				if (wdata_q[0] & ~start_q)
					first_q <= 1'b1;
			end
			if (capture)
				first_q <= 1'b0;
			// R15: sixteen-bit counter and buffer.
			cnt_q <= cnt_d;
			buf_q <= buf_d;
			// R8: sticky capture request, set beats clear.
			// R10: sticky overflow request, set beats clear.
			sts_q <= (sts_q & ~(wr_status ? wdata_q[`PPW_IRQ_W-1:0] : `PPW_IRQ_RST)) |
				{overflow, cap_irq};
			if (wr_mask)
				mask_q <= wdata_q[`PPW_IRQ_W-1:0];
			irq_q <= |(sts_q & mask_q);
		end
	end

	// Write channel: address and data are taken in either order and held until the
	// response is accepted, so only one write is in flight.
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= {`PPW_ADDR_W{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `PPW_RESP_OKAY;
		end else begin
			if (aw_fire) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[`PPW_ADDR_W-1:2], 2'b00};
			end
			if (w_fire) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? `PPW_RESP_OKAY : `PPW_RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
			if (bvalid_q & s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// R6: the value register reads the capture buffer.
	reg [31:0] rd_mux;
	reg rd_ok;
	always @* begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		case ({s_axi_araddr[`PPW_ADDR_W-1:2], 2'b00})
			`PPW_OFS_MODE: rd_mux[7:0] = mode_q;
			`PPW_OFS_VALUE: rd_mux[CNT_W-1:0] = buf_q;
			`PPW_OFS_START: rd_mux[0] = start_q;
			`PPW_OFS_STATUS: rd_mux[`PPW_IRQ_W-1:0] = sts_q;
			`PPW_OFS_MASK: rd_mux[`PPW_IRQ_W-1:0] = mask_q;
			`PPW_OFS_COUNT: rd_mux[CNT_W-1:0] = cnt_q;
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= `PPW_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (ar_fire) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= rd_ok ? `PPW_RESP_OKAY : `PPW_RESP_SLVERR;
			end
			if (rvalid_q & s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign irq = irq_q;

endmodule // ppw_measure

// *** ppw_pulse_src.sv ***
/* Pulse source on the measurement pin: a square wave with a settable half period.
   Assumes half stays at least 20 cycles, so edges sit well apart. */
`timescale 1ns/1ps
module ppw_pulse_src(
	input wire aclk,
	input wire en,
	input wire [15:0] half,
	output logic pin
);
	int n = 0;
	initial pin = 1'b0;
	always @(posedge aclk) begin
		if (!en) begin
			n <= 0;
			pin <= 1'b0;
		end else if (n + 1 >= half) begin
			n <= 0;
			pin <= ~pin;
		end else begin
			n <= n + 1;
		end
	end
endmodule // ppw_pulse_src

// *** ppw_measure_chk.sv ***
/* Bus and interrupt checker bound to the measurement timer.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ppw_measure_chk(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_RESP: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("late b");
	AST_RD_DATA: assert property (rd_taken |=> s_axi_rvalid) else $error("late r");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("b dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("r dropped");
	AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready early");
	AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar early");
	// The request only drops through a completed write, never by itself.
	AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(s_axi_bvalid) || !$past(aresetn))
		else $error("irq fell alone");
	AST_IRQ_QUIET: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("not idle");
endmodule // ppw_measure_chk
bind ppw_measure ppw_measure_chk i_ppw_measure_chk(.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq);

// *** ppw_measure_tb_top.sv ***
/* Self-checking bench for the measurement timer: AXI4-Lite tasks and a pulse source.
   Assumes the register map of ppw_regs.vh and one 125 MHz clock. */
`timescale 1ns/1ps
`include "ppw_regs.vh"
module ppw_measure_tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, en = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rs = 8'h47;
	logic [31:0] s_axi_wdata = 32'h0, d, m;
	logic [15:0] half = 16'h14;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, pin;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int n_fail = 0, n_checks = 0, h, f, p;
	ppw_measure i_ppw_measure(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pulse_measure_input(pin), .irq);
	ppw_pulse_src i_ppw_pulse_src(.aclk, .en, .half, .pin);
	always #4 aclk = ~aclk;
	function automatic [7:0] lfsr(input [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Ticks between effective edges; a tick on the capture edge itself is lost.
	function automatic int ticks(int k, int h);
		return ((k == 2) ? h : 2 * h) / ((k == 3) ? 16 : 2);
	endfunction
	task automatic chk(input [31:0] s, input [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] v, input [1:0] r);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Each channel is released at the edge that takes it, in whichever order.
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	task automatic rd(input [7:0] a, input [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk(s_axi_rresp, r);
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// The tests need about 1400 cycles; the span of 50000 cycles is over thirty times that.
	initial begin
		#400000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 6; a++) begin
			rd({a[5:0], 2'b00}, 0);
			chk(d, 0);
		end
		rd(8'h18, `PPW_RESP_SLVERR);
		chk(d, 0);
		wr(8'h18, 32'h1, `PPW_RESP_SLVERR);
		for (int k = 0; k < 4; k++) begin
			rs = lfsr(rs);
			h = (k == 3) ? 80 : 20 + 2 * rs[3:0];
			half <= h[15:0];
			m = {24'h0, (k == 3) ? `PPW_SRC_DIV16 : `PPW_SRC_DIV2, rs[5:4],
				(k == 3) ? `PPW_EDGE_RISE : k[1:0], `PPW_OP_MEASURE};
			wr(`PPW_OFS_MODE, m, 0);
			rd(`PPW_OFS_MODE, 0);
			chk(d, m & 32'hcf);
			wr(`PPW_OFS_MASK, 32'h1, 0);
			wr(`PPW_OFS_VALUE, 32'h0, 0);
			wr(`PPW_OFS_START, 32'h1, 0);
			en <= 1'b1;
			f = (k == 0) ? 2 * h : h;
			p = (k == 2) ? h : 2 * h;
			repeat (f + 6) @(posedge aclk);
			rd(`PPW_OFS_STATUS, 0);
			chk(d, 0);
			repeat (p) @(posedge aclk);
			rd(`PPW_OFS_STATUS, 0);
			chk(d, 1);
			chk(irq, 1);
			rd(`PPW_OFS_VALUE, 0);
			chk(d + 1 >= ticks(k, h) && d <= ticks(k, h), 1);
			en <= 1'b0;
			repeat (8) @(posedge aclk);
			wr(`PPW_OFS_STATUS, 32'h3, 0);
			rd(`PPW_OFS_STATUS, 0);
			chk(d, 0);
			chk(irq, 0);
		end
		// Edge code 11 captures nothing; the slowest source barely moves the counter.
		wr(`PPW_OFS_MODE, 32'hce, 0);
		wr(`PPW_OFS_VALUE, 32'h0, 0);
		wr(`PPW_OFS_START, 32'h1, 0);
		en <= 1'b1;
		repeat (400) @(posedge aclk);
		rd(`PPW_OFS_STATUS, 0);
		chk(d, 0);
		rd(`PPW_OFS_COUNT, 0);
		chk(d <= 1, 1);
		en <= 1'b0;
		wr(`PPW_OFS_MODE, 32'h06, 0);
		wr(`PPW_OFS_MASK, 32'h2, 0);
		wr(`PPW_OFS_VALUE, 32'hfff0, 0);
		wr(`PPW_OFS_START, 32'h1, 0);
		repeat (40) @(posedge aclk);
		rd(`PPW_OFS_STATUS, 0);
		chk(d, 2);
		chk(irq, 1);
		rd(`PPW_OFS_COUNT, 0);
		chk(d < 32'h10, 1);
		wr(`PPW_OFS_VALUE, 32'h1234, 0);
		rd(`PPW_OFS_COUNT, 0);
		chk(d, 32'h1234);
		rd(`PPW_OFS_VALUE, 0);
		chk(d, 32'h1234);
		report_and_stop;
	end
endmodule // ppw_measure_tb_top
